// ### pkg/tpa_pkg.sv
// constants for the timer with pulse accumulator
package tpa_pkg;
   // ----------------------------------------
   // bus and register indices (byte addr = 4 * index)
   // ----------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned IDX_W       = 6;
   localparam int unsigned CNT_W       = 16;
   localparam int unsigned PRESC_W     = 7;
   localparam logic [5:0]  IDX_DIR     = 6'h00;
   localparam logic [5:0]  IDX_FORCE   = 6'h01;
   localparam logic [5:0]  IDX_MASK7   = 6'h02;
   localparam logic [5:0]  IDX_DATA7   = 6'h03;
   localparam logic [5:0]  IDX_TIMER_COUNTER    = 6'h04;
   localparam logic [5:0]  IDX_ACT     = 6'h08;
   localparam logic [5:0]  IDX_CAPEDGE = 6'h0A;
   localparam logic [5:0]  IDX_IRQEN   = 6'h0C;
   localparam logic [5:0]  IDX_CTRL    = 6'h0D;
   localparam logic [5:0]  IDX_CFLG    = 6'h0E;
   localparam logic [5:0]  IDX_PORT    = 6'h0F;
   localparam logic [5:0]  IDX_CHV     = 6'h10;
   localparam logic [5:0]  IDX_ACTL    = 6'h20;
   localparam logic [5:0]  IDX_AFLG    = 6'h21;
   localparam logic [5:0]  IDX_ACNT    = 6'h22;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int unsigned CTRL_PSEL   = 0;
   localparam int unsigned CTRL_COUNTER_RESET_ON_MATCH   = 3;
   localparam int unsigned CTRL_FFC    = 4;
   localparam int unsigned CTRL_TEN    = 7;
   localparam int unsigned ACTL_EIE    = 0;
   localparam int unsigned ACTL_OIE    = 1;
   localparam int unsigned ACTL_CLK    = 2;
   localparam int unsigned ACTL_POL    = 4;
   localparam int unsigned ACTL_MODE   = 5;
   localparam int unsigned ACTL_EN     = 6;
   localparam int unsigned AFLG_EDGE   = 0;
   localparam int unsigned AFLG_OVF    = 1;
   // ----------------------------------------
   // encodings and reset values
   // ----------------------------------------
   localparam logic [1:0]  CLK_PRESC   = 2'h0;
   localparam logic [1:0]  CLK_ACC     = 2'h1;
   localparam logic [1:0]  CLK_DIV256  = 2'h2;
   localparam logic [1:0]  CLK_DIV64K  = 2'h3;
   localparam logic [1:0]  ACT_OFF     = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
   localparam logic [1:0]  ACT_CLEAR   = 2'h2;
   localparam logic [1:0]  ACT_SET     = 2'h3;
   localparam int unsigned EDGE_RISE   = 0;
   localparam int unsigned EDGE_FALL   = 1;
   localparam logic [5:0]  DIV64_ALL1  = 6'h3F;
   localparam logic [7:0]  LOW_ALL1    = 8'hFF;
   localparam logic [15:0] CNT_ALL1    = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO    = 16'h0000;
   localparam logic [7:0]  REG8_RST    = 8'h00;
endpackage : tpa_pkg

// ### src/tpa_timer_accum.sv
// timer with capture/compare channels and pulse accumulator, apb slave
`timescale 1ns/1ps
`default_nettype none

// Function
// - event mode counts selected edges on channel 7 pin; polarity 0 falling, 1 rising.
// - gated mode counts bus clock divided by 64 while pin at active level.
// - clock select picks prescaler, accumulator clock, clock/256 or clock/65536 for counter.
// - accumulator is 16 bits; wrap from all ones sets overflow flag.
// - accumulator flags clear on writing one; writing zero leaves them.
// - edge flag set by selected edge, or gate trailing edge in gated mode.
// - with fast clear set, any accumulator count access clears both flags.
// - accumulator input is synchronised to bus clock before counting.
// - prescaler divides bus clock by 1 to 128 via three-bit select.
// - input capture channel copies timer counter on active pin edge.
// - capture or compare sets channel flag; enable bit gates its interrupt.
// - compare match sets, clears or toggles pin; both bits zero disconnects.
// - force bit performs compare action at once without setting flag.
// - channel 7 compare overrides others, applying data bits to masked channels.
// - counter reset enable lets channel 7 match reset counter, even in accumulator use.
// - with reset enable and nonzero value, counter runs 0 to value, holds, returns.
// - port bit write on compare pin is latched, driven once pin is general output.
// - with accumulator disabled the counter always uses the prescaler clock.
// - divide-by-64 clock stops while the timer is disabled.
// - edge interrupt enable requests interrupt while edge flag is set.
module tpa_timer_accum #(
   parameter int unsigned NUM_CH = 4
) (
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_arst_n,
   input  wire logic                       i_psel,
   input  wire logic                       i_penable,
   input  wire logic                       i_pwrite,
   input  wire logic [tpa_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]                i_pwdata,
   output logic      [31:0]                o_prdata,
   output logic                            o_pready,
   output logic                            o_pslverr,
   input  wire logic [NUM_CH-1:0]          i_chan_pin,
   output logic      [NUM_CH-1:0]          o_chan_pin,
   output logic      [NUM_CH-1:0]          o_chan_pin_oe_n,
   output logic      [NUM_CH-1:0]          o_chan_irq,
   output logic                            o_accum_edge_irq,
   output logic                            o_accum_ovf_irq
);
   import tpa_pkg::*;

   localparam int unsigned TOP = NUM_CH - 1;

   if (NUM_CH < 1 || NUM_CH > 4) begin : g_chk
      $error("NUM_CH must be 1 to 4");
   end

   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   logic [1:0]        rst_q;
   logic              rst_n;
   logic [NUM_CH-1:0] pin_s1_q;
   logic [NUM_CH-1:0] pin_s2_q;
   logic [NUM_CH-1:0] pin_prev_q;

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // only the second stage and its delayed copy feed edge logic
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_s1_q   <= i_chan_pin;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic apply_act(input logic [1:0] act, input logic cur);
      case (act)
         ACT_TOGGLE: apply_act = ~cur;
         ACT_CLEAR:  apply_act = 1'b0;
         ACT_SET:    apply_act = 1'b1;
         default:    apply_act = cur;
      endcase
   endfunction : apply_act

   function automatic logic idx_ok(input logic [IDX_W-1:0] idx);
      idx_ok = (idx <= IDX_TIMER_COUNTER) || idx == IDX_ACT || idx == IDX_CAPEDGE
            || (idx >= IDX_IRQEN && idx <= IDX_PORT)
            || (idx >= IDX_CHV && idx < IDX_CHV + 6'(NUM_CH))
            || (idx >= IDX_ACTL && idx <= IDX_ACNT);
   endfunction : idx_ok

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [NUM_CH-1:0]   dir_q, dir_d, mask7_q, mask7_d, data7_q, data7_d;
   logic [NUM_CH-1:0]   irqen_q, irqen_d, cflg_q, cflg_d, port_q, port_d;
   logic [NUM_CH-1:0]   cmp_q, cmp_d, pin_q, pin_d;
   logic [7:0]          act_q, act_d, capedge_q, capedge_d, ctrl_q, ctrl_d;
   logic [7:0]          actl_q, actl_d;
   logic [1:0]          aflg_q, aflg_d;
   logic [CNT_W-1:0]    timer_counter_q, timer_counter_d, acnt_q, acnt_d;
   logic [CNT_W-1:0]    chv_q [NUM_CH];
   logic [CNT_W-1:0]    chv_d [NUM_CH];
   logic [PRESC_W-1:0]  pcnt_q, pcnt_d;
   logic                upd_q, upd_d;
   logic [31:0]         rdata_q, rdata_d;
   logic                err_q, err_d;

   // ----------------------------------------
   // decode and events
   // ----------------------------------------
   logic [IDX_W-1:0]    idx;
   logic                setup, access, wr, acnt_touch;
   logic                timer_enable, acc_en, gated, pol, sel_edge, gate_on;
   logic                presc_tick, div64, acc_inc, tick, counter_reset_on_match_hit;
   logic [PRESC_W-1:0]  pmask;
   logic [NUM_CH-1:0]   rise, fall, cap_evt, cmp_evt, force_evt;

   assign idx        = i_paddr[IDX_W+1:2];
   assign setup      = i_psel & ~i_penable;
   assign access     = i_psel & i_penable;
   assign wr         = access & i_pwrite & ~err_q;
   assign acnt_touch = access & ~err_q & idx == IDX_ACNT & ctrl_q[CTRL_FFC];
   assign timer_enable        = ctrl_q[CTRL_TEN];
   assign acc_en     = actl_q[ACTL_EN];
   assign gated      = actl_q[ACTL_MODE];
   assign pol        = actl_q[ACTL_POL];
   assign rise       = pin_s2_q & ~pin_prev_q;
   assign fall       = ~pin_s2_q & pin_prev_q;
   // trailing edge of the active gate level is the same edge as event mode
   assign sel_edge   = pol ? rise[TOP] : fall[TOP];
   assign gate_on    = pol ? ~pin_s2_q[TOP] : pin_s2_q[TOP];
   assign pmask      = PRESC_W'((8'h01 << ctrl_q[CTRL_PSEL +: 3]) - 8'h01);
   assign presc_tick = timer_enable & ((pcnt_q & pmask) == pmask);
   assign div64      = timer_enable & (pcnt_q[5:0] == DIV64_ALL1);
   assign acc_inc    = acc_en & (gated ? (div64 & gate_on) : sel_edge);

   always_comb begin
      tick = presc_tick;
      if (acc_en) begin
         case (actl_q[ACTL_CLK +: 2])
            CLK_PRESC:  tick = presc_tick;
            CLK_ACC:    tick = acc_inc;
            CLK_DIV256: tick = acc_inc & (acnt_q[7:0] == LOW_ALL1);
            CLK_DIV64K: tick = acc_inc & (acnt_q == CNT_ALL1);
            default:    tick = presc_tick;
         endcase
      end
      tick = tick & timer_enable;
   end

   // counter holds the channel 7 value for one count period, then wraps
   assign counter_reset_on_match_hit = ctrl_q[CTRL_COUNTER_RESET_ON_MATCH] & (chv_q[TOP] != CNT_ZERO)
                   & (timer_counter_q == chv_q[TOP]);

   for (genvar g = 0; g < NUM_CH; g++) begin : g_evt
      assign cap_evt[g]   = ~dir_q[g] & ((capedge_q[2*g+EDGE_RISE] & rise[g])
                          | (capedge_q[2*g+EDGE_FALL] & fall[g]));
      assign cmp_evt[g]   = dir_q[g] & upd_q & (timer_counter_q == chv_q[g]);
      assign force_evt[g] = wr & idx == IDX_FORCE & i_pwdata[g];
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      dir_d     = dir_q;
      mask7_d   = mask7_q;
      data7_d   = data7_q;
      irqen_d   = irqen_q;
      port_d    = port_q;
      act_d     = act_q;
      capedge_d = capedge_q;
      ctrl_d    = ctrl_q;
      actl_d    = actl_q;
      chv_d     = chv_q;
      cflg_d    = cflg_q;
      aflg_d    = aflg_q;
      cmp_d     = cmp_q;
      acnt_d    = acnt_q;
      pcnt_d    = timer_enable ? pcnt_q + 1'b1 : '0;
      timer_counter_d    = timer_counter_q;
      upd_d     = tick;
      // software writes first, so hardware events below win over a clear
      if (wr) begin
         case (idx)
            IDX_DIR:     dir_d     = i_pwdata[NUM_CH-1:0];
            IDX_MASK7:   mask7_d   = i_pwdata[NUM_CH-1:0];
            IDX_DATA7:   data7_d   = i_pwdata[NUM_CH-1:0];
            IDX_IRQEN:   irqen_d   = i_pwdata[NUM_CH-1:0];
            IDX_PORT:    port_d    = i_pwdata[NUM_CH-1:0];
            IDX_ACT:     act_d     = i_pwdata[7:0];
            IDX_CAPEDGE: capedge_d = i_pwdata[7:0];
            IDX_CTRL:    ctrl_d    = i_pwdata[7:0];
            IDX_CFLG:    cflg_d    = cflg_q & ~i_pwdata[NUM_CH-1:0];
            IDX_ACTL:    actl_d    = i_pwdata[7:0];
            IDX_AFLG:    aflg_d    = aflg_q & ~i_pwdata[1:0];
            IDX_ACNT:    acnt_d    = i_pwdata[CNT_W-1:0];
            default: begin
               for (int k = 0; k < NUM_CH; k++) begin
                  if (idx == IDX_CHV + 6'(k) && dir_q[k]) begin
                     chv_d[k] = i_pwdata[CNT_W-1:0];
                  end
               end
            end
         endcase
      end
      if (acnt_touch) begin
         aflg_d = 2'h0;
      end
      if (acc_inc && !(wr && idx == IDX_ACNT)) begin
         acnt_d = acnt_q + 1'b1;
         if (acnt_q == CNT_ALL1) begin
            aflg_d[AFLG_OVF] = 1'b1;
         end
      end
      if (acc_en && sel_edge) begin
         aflg_d[AFLG_EDGE] = 1'b1;
      end
      if (tick) begin
         timer_counter_d = counter_reset_on_match_hit ? CNT_ZERO : timer_counter_q + 1'b1;
      end
      for (int k = 0; k < NUM_CH; k++) begin
         if (cap_evt[k]) begin
            chv_d[k] = timer_counter_q;
         end
         if (cap_evt[k] || cmp_evt[k]) begin
            cflg_d[k] = 1'b1;
         end
         if (cmp_evt[k] || force_evt[k]) begin
            cmp_d[k] = apply_act(act_q[2*k +: 2], cmp_q[k]);
         end
      end
      if (dir_q[TOP] && (cmp_evt[TOP] || force_evt[TOP])) begin
         for (int k = 0; k < NUM_CH; k++) begin
            if (mask7_q[k]) begin
               cmp_d[k] = data7_q[k];
            end
         end
      end
      for (int k = 0; k < NUM_CH; k++) begin
         // a disconnected output pin shows the port latch instead
         pin_d[k] = (act_q[2*k +: 2] != ACT_OFF || (mask7_q[k] && dir_q[TOP]))
                  ? cmp_d[k] : port_d[k];
      end
   end

   // ----------------------------------------
   // apb read path, sampled in the setup cycle
   // ----------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      err_d   = err_q;
      if (setup) begin
         err_d   = ~idx_ok(idx) | (i_paddr[1:0] != 2'h0);
         rdata_d = 32'h0000_0000;
         case (idx)
            IDX_DIR:     rdata_d[NUM_CH-1:0] = dir_q;
            IDX_MASK7:   rdata_d[NUM_CH-1:0] = mask7_q;
            IDX_DATA7:   rdata_d[NUM_CH-1:0] = data7_q;
            IDX_TIMER_COUNTER:    rdata_d[CNT_W-1:0]  = timer_counter_q;
            IDX_IRQEN:   rdata_d[NUM_CH-1:0] = irqen_q;
            IDX_CFLG:    rdata_d[NUM_CH-1:0] = cflg_q;
            IDX_PORT:    rdata_d[NUM_CH-1:0] = port_q;
            IDX_ACT:     rdata_d[7:0]        = act_q;
            IDX_CAPEDGE: rdata_d[7:0]        = capedge_q;
            IDX_CTRL:    rdata_d[7:0]        = ctrl_q;
            IDX_ACTL:    rdata_d[7:0]        = actl_q;
            IDX_AFLG:    rdata_d[1:0]        = aflg_q;
            IDX_ACNT:    rdata_d[CNT_W-1:0]  = acnt_q;
            default: begin
               for (int k = 0; k < NUM_CH; k++) begin
                  if (idx == IDX_CHV + 6'(k)) begin
                     rdata_d[CNT_W-1:0] = chv_q[k];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dir_q     <= '0;
         mask7_q   <= '0;
         data7_q   <= '0;
         irqen_q   <= '0;
         port_q    <= '0;
         cflg_q    <= '0;
         cmp_q     <= '0;
         pin_q     <= '0;
         act_q     <= REG8_RST;
         capedge_q <= REG8_RST;
         ctrl_q    <= REG8_RST;
         actl_q    <= REG8_RST;
         aflg_q    <= 2'h0;
         acnt_q    <= CNT_ZERO;
         timer_counter_q    <= CNT_ZERO;
         chv_q     <= '{default: CNT_ZERO};
         pcnt_q    <= '0;
         upd_q     <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         err_q     <= 1'b0;
      end else begin
         dir_q     <= dir_d;
         mask7_q   <= mask7_d;
         data7_q   <= data7_d;
         irqen_q   <= irqen_d;
         port_q    <= port_d;
         cflg_q    <= cflg_d;
         cmp_q     <= cmp_d;
         pin_q     <= pin_d;
         act_q     <= act_d;
         capedge_q <= capedge_d;
         ctrl_q    <= ctrl_d;
         actl_q    <= actl_d;
         aflg_q    <= aflg_d;
         acnt_q    <= acnt_d;
         timer_counter_q    <= timer_counter_d;
         chv_q     <= chv_d;
         pcnt_q    <= pcnt_d;
         upd_q     <= upd_d;
         rdata_q   <= rdata_d;
         err_q     <= err_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_prdata         = rdata_q;
   assign o_pready         = access;
   assign o_pslverr        = access & err_q;
   assign o_chan_pin       = pin_q;
   assign o_chan_pin_oe_n  = ~dir_q;
   assign o_chan_irq       = cflg_q & irqen_q;
   assign o_accum_edge_irq = aflg_q[AFLG_EDGE] & actl_q[ACTL_EIE];
   assign o_accum_ovf_irq  = aflg_q[AFLG_OVF] & actl_q[ACTL_OIE];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n);

   logic acnt_wr;
   assign acnt_wr = wr & idx == IDX_ACNT;

   accum_evt_inc_a: assert property (
      acc_en && !gated && sel_edge && !acnt_wr |=> acnt_q == $past(acnt_q) + 16'h0001)
      else $error("event edge did not advance accumulator");
   gated_hold_a: assert property (
      acc_en && gated && !gate_on && !acnt_wr |=> acnt_q == $past(acnt_q))
      else $error("accumulator counted outside the gate");
   accum_ovf_a: assert property (
      acc_inc && acnt_q == CNT_ALL1 && !acnt_wr |=> aflg_q[AFLG_OVF] && acnt_q == CNT_ZERO)
      else $error("accumulator wrap did not set overflow");
   flag_w1c_a: assert property (
      wr && idx == IDX_AFLG && !i_pwdata[AFLG_OVF] && aflg_q[AFLG_OVF] |=> aflg_q[AFLG_OVF])
      else $error("writing zero cleared the overflow flag");
   fast_clear_a: assert property (
      acnt_touch && !acc_inc && !sel_edge |=> aflg_q == 2'h0)
      else $error("fast clear left an accumulator flag set");
   capture_val_a: assert property (
      cap_evt[0] |=> chv_q[0] == $past(timer_counter_q) && cflg_q[0])
      else $error("capture did not store the counter");
   force_noflag_a: assert property (
      force_evt[0] && !cmp_evt[0] && !cap_evt[0] && !cflg_q[0] && !(wr && idx == IDX_CFLG)
      |=> !cflg_q[0])
      else $error("forced compare set the channel flag");
   counter_reset_on_match_wrap_a: assert property (
      tick && counter_reset_on_match_hit |=> timer_counter_q == CNT_ZERO)
      else $error("counter did not wrap at channel 7 value");
   presc_hold_a: assert property (
      !acc_en && !presc_tick |=> timer_counter_q == $past(timer_counter_q))
      else $error("counter advanced without a prescaler tick");
   div64_off_a: assert property (
      !timer_enable && gated && !acnt_wr |=> acnt_q == $past(acnt_q) && timer_counter_q == $past(timer_counter_q))
      else $error("timer clock ran while disabled");

endmodule : tpa_timer_accum

`default_nettype wire

// ### verif/tpa_pin_model.sv
// external source model that drives the channel pins
`timescale 1ns/1ps
`default_nettype none
module tpa_pin_model (
   input  wire logic       i_clk_sys,
   input  wire logic [3:0] i_want,
   input  wire logic [3:0] i_dout,
   input  wire logic [3:0] i_oe_n,
   output logic      [3:0] o_pin
);
   logic [3:0] lvl_q = 4'h0;
   int         age_q[4] = '{default: 0};
   // a new level waits until the old one stood 5 clocks
   always @(posedge i_clk_sys) begin
      for (int b = 0; b < 4; b++) begin
         if (lvl_q[b] != i_want[b] && age_q[b] >= 4) begin
            lvl_q[b] <= i_want[b];
            age_q[b] <= 0;
         end else begin
            age_q[b] <= age_q[b] + 1;
         end
      end
   end
   // the device wins wherever its drive is on
   assign o_pin = (i_dout & ~i_oe_n) | (lvl_q & i_oe_n);
endmodule : tpa_pin_model
`default_nettype wire

// ### verif/tpa_timer_accum_tb.sv
// self-checking bench for the timer with pulse accumulator
`timescale 1ns/1ps
`default_nettype none
module tpa_timer_accum_tb;
   import tpa_pkg::*;
   logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_v, ch7_lim;
   logic        pready, pslverr, err_v, eirq, oirq;
   logic [3:0]  want = 4'h0, pin, dout, oe_n, cirq;
   int          err_count = 0, samples_checked = 0;
   always #5 clk = ~clk;
   tpa_timer_accum tpa_timer_accum_inst (.i_clk_sys(clk), .i_arst_n(arst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_chan_pin(pin), .o_chan_pin(dout),
      .o_chan_pin_oe_n(oe_n), .o_chan_irq(cirq), .o_accum_edge_irq(eirq), .o_accum_ovf_irq(oirq));
   tpa_pin_model tpa_pin_model_inst (.i_clk_sys(clk), .i_want(want), .i_dout(dout), .i_oe_n(oe_n),
      .o_pin(pin));
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one apb transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         $display("BAD pready expected 1 seen timeout");
         close_out();
      end
   endtask : apb
   task automatic rchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(what, exp, rd_v);
   endtask : rchk
   task automatic pin_to(input int b, input logic v, input int hold);
      want[b] <= v;
      repeat (hold) @(posedge clk);
   endtask : pin_to
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("count after reset", IDX_ACNT, 32'h0);
      rchk("flags after reset", IDX_AFLG, 32'h0);
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, IDX_ACNT, 32'h0);
         apb(1'b1, IDX_AFLG, 32'h3);
         apb(1'b1, IDX_ACTL, 32'h40 | (p << 4));
         pin_to(3, 1'b1, 12);
         rchk("count after rise", IDX_ACNT, p);
         pin_to(3, 1'b0, 12);
         rchk("count after fall", IDX_ACNT, 32'h1);
         rchk("edge flag", IDX_AFLG, 32'h1);
      end
      apb(1'b1, IDX_AFLG, 32'h0);
      rchk("flags kept by zero", IDX_AFLG, 32'h1);
      apb(1'b1, IDX_AFLG, 32'h1);
      rchk("flags cleared by one", IDX_AFLG, 32'h0);
      apb(1'b1, IDX_ACTL, 32'h53);
      apb(1'b1, IDX_ACNT, 32'hFFFF);
      pin_to(3, 1'b1, 12);
      pin_to(3, 1'b0, 12);
      rchk("count wrap", IDX_ACNT, 32'h0);
      rchk("overflow flag", IDX_AFLG, 32'h3);
      chk("irq lines", 2'h3, {oirq, eirq});
      apb(1'b1, IDX_AFLG, 32'h1);
      rchk("overflow kept", IDX_AFLG, 32'h2);
      apb(1'b1, IDX_CTRL, 32'h10);
      rchk("count read", IDX_ACNT, 32'h0);
      rchk("flags fast cleared", IDX_AFLG, 32'h0);
      apb(1'b1, IDX_CTRL, 32'h80);
      apb(1'b1, IDX_ACTL, 32'h60);
      apb(1'b1, IDX_ACNT, 32'h0);
      pin_to(3, 1'b1, 300);
      pin_to(3, 1'b0, 12);
      apb(1'b0, IDX_ACNT, 32'h0);
      chk("gated ticks", 1'b1, rd_v >= 4 && rd_v <= 5);
      rchk("gate trailing edge", IDX_AFLG, 32'h1);
      apb(1'b1, IDX_CTRL, 32'h0);
      apb(1'b1, IDX_ACNT, 32'h0);
      pin_to(3, 1'b1, 200);
      rchk("gated with timer off", IDX_ACNT, 32'h0);
      pin_to(3, 1'b0, 12);
      apb(1'b1, IDX_CTRL, 32'h80);
      apb(1'b1, IDX_CAPEDGE, 32'h1);
      apb(1'b1, IDX_IRQEN, 32'h1);
      pin_to(0, 1'b1, 12);
      rchk("capture flag", IDX_CFLG, 32'h1);
      chk("channel irq", 1'b1, cirq[0]);
      apb(1'b0, IDX_CHV, 32'h0);
      chk("captured value", 1'b1, rd_v != 0);
      apb(1'b1, IDX_DIR, 32'h2);
      apb(1'b1, IDX_ACT, 32'hC);
      apb(1'b1, IDX_CFLG, 32'h1);
      apb(1'b1, IDX_FORCE, 32'h3);
      repeat (3) @(posedge clk);
      chk("forced pin", 2'h1, {oe_n[1], dout[1]});
      apb(1'b0, IDX_CFLG, 32'h0);
      chk("no flag on force", 32'h0, rd_v);
      apb(1'b1, IDX_ACT, 32'h8);
      apb(1'b1, IDX_FORCE, 32'h2);
      apb(1'b1, IDX_PORT, 32'h2);
      repeat (2) @(posedge clk);
      chk("pin kept on port write", 32'h0, dout[1]);
      apb(1'b1, IDX_ACT, 32'h0);
      repeat (2) @(posedge clk);
      chk("port latch on pin", 32'h1, dout[1]);
      // channel 7 limit sits well ahead of the running count, so the wrap comes soon
      apb(1'b1, IDX_DIR, 32'hA);
      apb(1'b1, IDX_CTRL, 32'h88);
      apb(1'b0, IDX_TIMER_COUNTER, 32'h0);
      ch7_lim = rd_v + 32'h40;
      apb(1'b1, IDX_CHV + 6'h03, ch7_lim);
      repeat (200) @(posedge clk);
      apb(1'b0, IDX_TIMER_COUNTER, 32'h0);
      chk("counter held under ch7", 1'b1, rd_v < ch7_lim);
      apb(1'b0, 6'h3F, 32'h0);
      chk("unmapped error", 32'h1, 32'(err_v));
      chk("unmapped read", 32'h0, rd_v);
      close_out();
   end
endmodule : tpa_timer_accum_tb
`default_nettype wire
